// ===== rtl/pif_pkg.sv
// Package: register map, bit positions and bus types of the peripheral flag bank
`default_nettype none
package pif_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_FLAGS_A   = 12'h000;
    localparam logic [11:0] OFS_FLAGS_B   = 12'h004;
    localparam logic [11:0] OFS_ENABLES_A = 12'h008;
    localparam logic [11:0] OFS_GATES     = 12'h00c;
    localparam logic [11:0] OFS_ENABLES_B = 12'h010;
    // Reset values
    localparam logic [7:0] FLAGS_A_RST   = 8'h00;
    localparam logic [7:0] FLAGS_B_RST   = 8'h00;
    localparam logic [7:0] ENABLES_A_RST = 8'h00;
    localparam logic [2:0] GATES_RST     = 3'h0;
    localparam logic [3:0] ENABLES_B_RST = 4'h0;
    // Implemented bits of the second flag register
    localparam logic [7:0] FLAGS_B_MASK  = 8'h0f;
    // First flag register bit positions
    localparam int A_PARALLEL    = 7;
    localparam int A_CONVERTER   = 6;
    localparam int A_RECEIVE     = 5;
    localparam int A_TRANSMIT    = 4;
    localparam int A_SERIAL      = 3;
    localparam int A_CAPCOMP1    = 2;
    localparam int A_TIMER2      = 1;
    localparam int A_TIMER1      = 0;
    // Second flag register bit positions
    localparam int B_COLLISION   = 3;
    localparam int B_LOW_VOLTAGE = 2;
    localparam int B_TIMER3      = 1;
    localparam int B_CAPCOMP2    = 0;
    // Gate register bit positions
    localparam int G_PERIPH      = 0;
    localparam int G_GLOBAL      = 1;
    localparam int G_PRIORITY    = 2;

    // Capture/compare unit operating modes
    typedef enum logic [1:0] {
        CC_OFF     = 2'b00,
        CC_CAPTURE = 2'b01,
        CC_COMPARE = 2'b10,
        CC_PWM     = 2'b11
    } capcomp_mode_t;

    // Single-cycle peripheral event pulses
    typedef struct packed {
        logic parallel_port;
        logic converter_done;
        logic receive_full;
        logic transmit_empty;
        logic serial_done;
        logic capcomp1_event;
        logic timer2_match;
        logic timer1_overflow;
        logic bus_collision;
        logic low_voltage;
        logic timer3_overflow;
        logic capcomp2_event;
    } periph_events_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
endpackage
`default_nettype wire

// ===== rtl/capcomp_event_gate.sv
// Mode gate that qualifies one capture/compare unit's raw events
`default_nettype none
module capcomp_event_gate
    import pif_pkg::*;
(
    input  wire pif_pkg::capcomp_mode_t mode,
    input  wire logic                   capture_strobe,
    input  wire logic                   compare_match,
    output logic                        flag_event
);
    // Pulse-width mode never raises the flag
    always_comb begin
        case (mode)
            CC_CAPTURE: flag_event = capture_strobe;
            CC_COMPARE: flag_event = compare_match;
            CC_PWM:     flag_event = 1'b0;
            default:    flag_event = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ===== rtl/peripheral_interrupt_flags.sv
// Peripheral interrupt flag and enable bank with an APB register slave
//
// Functional notes
// (R1) First capcomp flag sets on timer1 compare match in compare mode; held until cleared.
// (R2) In pulse-width mode a capcomp unit never sets its flag.
// (R3) Timer2 count equal to period value sets first-register bit 1; software clears.
// (R4) Timer1 overflow sets first-register bit 0; held until software clears.
// (R5) Second-register bits 7..4 read zero; writes to them ignored.
// (R6) Serial bus collision sets second-register bit 3; software clears.
// (R7) Low-voltage trip sets second-register bit 2; software clears.
// (R8) Timer3 overflow sets second-register bit 1; software clears.
// (R9) Second capcomp capture or compare sets second-register bit 0; software clears.
// (R10) First enable register: eight RW bits, zero after reset.
// (R11) Flags set regardless of enable or global gate bits.
// (R12) Without priority scheme, request also needs the peripheral gate bit.
// (R13) Request is OR over all flag-and-enable pairs.
// (R14) Event in the clearing cycle wins; flag stays set.
`default_nettype none
module peripheral_interrupt_flags
    import pif_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire pif_pkg::apb_req_t      apb_req,
    output pif_pkg::apb_rsp_t           apb_rsp,
    input  wire pif_pkg::periph_events_t events,
    input  wire pif_pkg::capcomp_mode_t capcomp1_mode,
    input  wire pif_pkg::capcomp_mode_t capcomp2_mode,
    input  wire logic                   capcomp2_capture,
    input  wire logic                   capcomp2_compare,
    output logic                        peripheral_irq,
    output logic [7:0]                  pending_a,
    output logic [3:0]                  pending_b
);
    import pif_pkg::*;

    logic [7:0]  flags_a_r;
    logic [7:0]  flags_a_nxt;
    logic [7:0]  flags_b_r;
    logic [7:0]  flags_b_nxt;
    logic [7:0]  enables_a_r;
    logic [7:0]  enables_a_nxt;
    logic [3:0]  enables_b_r;
    logic [3:0]  enables_b_nxt;
    logic [2:0]  gates_r;
    logic [2:0]  gates_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        irq_r;
    logic        irq_nxt;
    logic [7:0]  set_a;
    logic [7:0]  set_b;
    logic        cc1_event;
    logic        cc2_event;
    logic        wr_en;
    logic        rd_en;
    logic        addr_hit;

    // Address decode used only for the error response of reads and writes
    function automatic logic is_mapped(input logic [11:0] a);
        return (a == OFS_FLAGS_A) || (a == OFS_FLAGS_B) || (a == OFS_ENABLES_A)
            || (a == OFS_GATES) || (a == OFS_ENABLES_B);
    endfunction

    // Sticky flag update: set beats clear
    function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
                                          input logic wr, input logic [7:0] wdata);
        logic [7:0] held;
        held = wr ? (cur & wdata) : cur;
        return held | set;
    endfunction

    // (R1) first capcomp qualified
    capcomp_event_gate u_cc1 (
        .mode           (capcomp1_mode),
        .capture_strobe (events.capcomp1_event),
        .compare_match  (events.capcomp1_event),
        .flag_event     (cc1_event)
    );

    // (R9) second capcomp qualified
    capcomp_event_gate u_cc2 (
        .mode           (capcomp2_mode),
        .capture_strobe (capcomp2_capture),
        .compare_match  (capcomp2_compare),
        .flag_event     (cc2_event)
    );

    // APB strobes: write in the access phase, read in the setup phase; zero wait states
    assign wr_en    = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_en    = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign addr_hit = is_mapped(apb_req.paddr);

    // Event set vectors, independent of every enable (R11)
    always_comb begin
        set_a = 8'h00;
        set_b = 8'h00;
        set_a[A_PARALLEL]    = events.parallel_port;
        set_a[A_CONVERTER]   = events.converter_done;
        set_a[A_RECEIVE]     = events.receive_full;
        set_a[A_TRANSMIT]    = events.transmit_empty;
        set_a[A_SERIAL]      = events.serial_done;
        // (R2) pwm masks capcomp
        set_a[A_CAPCOMP1]    = cc1_event;
        // (R3) timer2 period match
        set_a[A_TIMER2]      = events.timer2_match;
        // (R4) timer1 overflow
        set_a[A_TIMER1]      = events.timer1_overflow;
        // (R6) bus collision
        set_b[B_COLLISION]   = events.bus_collision;
        // (R7) low voltage
        set_b[B_LOW_VOLTAGE] = events.low_voltage;
        // (R8) timer3 overflow
        set_b[B_TIMER3]      = events.timer3_overflow;
        // (R9) second capcomp event
        set_b[B_CAPCOMP2]    = cc2_event;
    end

    // Flag next values
    always_comb begin
        // (R14) set wins clear
        flags_a_nxt   = sticky(flags_a_r, set_a,
                               wr_en && apb_req.paddr == OFS_FLAGS_A, apb_req.pwdata[7:0]);
        // (R5) upper bits masked
        flags_b_nxt   = sticky(flags_b_r, set_b,
                               wr_en && apb_req.paddr == OFS_FLAGS_B, apb_req.pwdata[7:0])
                        & FLAGS_B_MASK;
    end

    // Enable and gate next values; plain read/write storage
    always_comb begin
        // (R10) enable register write
        enables_a_nxt = (wr_en && apb_req.paddr == OFS_ENABLES_A) ? apb_req.pwdata[7:0] : enables_a_r;
        enables_b_nxt = (wr_en && apb_req.paddr == OFS_ENABLES_B) ? apb_req.pwdata[3:0] : enables_b_r;
        gates_nxt     = (wr_en && apb_req.paddr == OFS_GATES) ? apb_req.pwdata[2:0] : gates_r;
    end

    // Reading has no side effect, so polling never loses an event
    // Read data captured in the setup cycle, shown in the access phase
    always_comb begin
        prdata_nxt = prdata_r;
        if (rd_en) begin
            case (apb_req.paddr)
                OFS_FLAGS_A:   prdata_nxt = {24'h000000, flags_a_r};
                OFS_FLAGS_B:   prdata_nxt = {24'h000000, flags_b_r & FLAGS_B_MASK};
                OFS_ENABLES_A: prdata_nxt = {24'h000000, enables_a_r};
                OFS_GATES:     prdata_nxt = {29'h0, gates_r};
                OFS_ENABLES_B: prdata_nxt = {28'h0000000, enables_b_r};
                default:       prdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Request combine, registered to keep the output glitch free
    always_comb begin
        logic any_pending;
        any_pending = 1'b0;
        // (R13) or of flag and enable
        any_pending = |(flags_a_r & enables_a_r) | |(flags_b_r[3:0] & enables_b_r);
        // Global gate only stored; the core applies it downstream
        // (R12) gate when no priority
        if (gates_r[G_PRIORITY])
            irq_nxt = any_pending;
        else
            irq_nxt = any_pending && gates_r[G_PERIPH];
    end

    // Flag registers; power-on leaves nothing pending
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_a_r <= FLAGS_A_RST;
            flags_b_r <= FLAGS_B_RST;
        end else begin
            flags_a_r <= flags_a_nxt;
            flags_b_r <= flags_b_nxt;
        end
    end

    // Enable and gate registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enables_a_r <= ENABLES_A_RST;
            enables_b_r <= ENABLES_B_RST;
            gates_r     <= GATES_RST;
        end else begin
            enables_a_r <= enables_a_nxt;
            enables_b_r <= enables_b_nxt;
            gates_r     <= gates_nxt;
        end
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    // Request register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // Outputs
    always_comb begin
        apb_rsp.pready  = 1'b1;
        // Unmapped offsets answer with an error and change nothing
        apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_hit;
        apb_rsp.prdata  = prdata_r;
    end
    assign peripheral_irq = irq_r;
    assign pending_a      = flags_a_r;
    assign pending_b      = flags_b_r[3:0];
endmodule
`default_nettype wire

// ===== sim/pif_monitor.sv
// Checker of flag setting, holding and request behaviour at the bank's ports
`default_nettype none
module pif_monitor
    import pif_pkg::*;
(
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire pif_pkg::apb_req_t       apb_req,
    input wire pif_pkg::periph_events_t events,
    input wire pif_pkg::capcomp_mode_t  capcomp1_mode,
    input wire pif_pkg::capcomp_mode_t  capcomp2_mode,
    input wire logic                    capcomp2_capture,
    input wire logic                    peripheral_irq,
    input wire logic [7:0]              pending_a,
    input wire logic [3:0]              pending_b
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Timer1 flag up while no write reaches its register
    sequence t1_held;
        pending_a[A_TIMER1] && !(apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == OFS_FLAGS_A);
    endsequence
    // Capcomp1 idle in pulse-width mode
    sequence cc1_pwm_clear;
        capcomp1_mode == CC_PWM && !pending_a[A_CAPCOMP1];
    endsequence
    // Unit 1 match while in compare mode
    sequence cc1_compare;
        capcomp1_mode == CC_COMPARE && events.capcomp1_event;
    endsequence
    // Unit 2 capture strobe while in capture mode
    sequence cc2_capture;
        capcomp2_mode == CC_CAPTURE && capcomp2_capture;
    endsequence
    t1_overflow_a: assert property (events.timer1_overflow |=> pending_a[A_TIMER1]) else $error("no t1 flag");
    flag_sticky_a: assert property (t1_held |=> pending_a[A_TIMER1]) else $error("t1 flag lost");
    t2_match_a: assert property (events.timer2_match |=> pending_a[A_TIMER2]) else $error("no t2 flag");
    cc1_compare_a: assert property (cc1_compare |=> pending_a[A_CAPCOMP1])
        else $error("no cc1 flag");
    pwm_silent_a: assert property (cc1_pwm_clear |=> !pending_a[A_CAPCOMP1]) else $error("cc1 set in pwm");
    collision_set_a: assert property (events.bus_collision |=> pending_b[B_COLLISION]) else $error("no bcl");
    low_volt_a: assert property (events.low_voltage |=> pending_b[B_LOW_VOLTAGE]) else $error("no lv flag");
    t3_overflow_a: assert property (events.timer3_overflow |=> pending_b[B_TIMER3]) else $error("no t3 flag");
    cc2_capture_a: assert property (cc2_capture |=> pending_b[B_CAPCOMP2])
        else $error("no cc2 flag");
    irq_cause_a: assert property (peripheral_irq |-> $past(pending_a) != 8'h00 || $past(pending_b) != 4'h0)
        else $error("irq without flag");
endmodule
bind peripheral_interrupt_flags pif_monitor i_pif_monitor (.pclk, .presetn, .apb_req, .events, .capcomp1_mode,
    .capcomp2_mode, .capcomp2_capture, .peripheral_irq, .pending_a, .pending_b);
`default_nettype wire

// ===== sim/event_source_model.sv
// Model of the on-chip peripherals: bench requests become one-cycle event pulses
`default_nettype none
module event_source_model
    import pif_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic [12:0]        fire,
    output pif_pkg::periph_events_t events,
    output logic                    capcomp2_capture,
    output logic                    capcomp2_compare
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [12:0] pulse_r;
    // Registered so a pulse starts cleanly after an edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_r <= 13'h0000;
        end else begin
            pulse_r <= fire;
        end
    end
    // Unit 2 uses its own strobes, so its struct field stays low
    assign events = {pulse_r[11:1], 1'b0};
    assign capcomp2_capture = pulse_r[0];
    assign capcomp2_compare = pulse_r[12];
endmodule
`default_nettype wire

// ===== sim/peripheral_interrupt_flags_test.sv
// Self-checking bench of the peripheral flag bank
`default_nettype none
module peripheral_interrupt_flags_test;
    timeunit 1ns;
    timeprecision 1ns;
    import pif_pkg::*;
    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    apb_req_t       apb_req = '0;
    apb_rsp_t       apb_rsp;
    periph_events_t events;
    capcomp_mode_t  capcomp1_mode = CC_COMPARE;
    capcomp_mode_t  capcomp2_mode = CC_CAPTURE;
    logic           capcomp2_capture;
    logic           capcomp2_compare;
    logic           peripheral_irq;
    logic [7:0]     pending_a;
    logic [3:0]     pending_b;
    logic [12:0]    fire = '0;
    int             error_cnt = 0;
    int             num_checks = 0;
    logic           last_err = 1'b0;

    peripheral_interrupt_flags i_peripheral_interrupt_flags (.pclk, .presetn, .apb_req, .apb_rsp, .events,
        .capcomp1_mode, .capcomp2_mode, .capcomp2_capture, .capcomp2_compare, .peripheral_irq, .pending_a, .pending_b);
    event_source_model i_event_source_model (.pclk, .presetn, .fire, .events, .capcomp2_capture, .capcomp2_compare);

    // 125 MHz clock
    initial forever #4 pclk = ~pclk;

    task automatic give_verdict();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (apb_rsp.pready === 1'b1) break;
        end
        if (n == 16) begin
            error_cnt++;
            give_verdict();
        end
        r = apb_rsp.prdata;
        last_err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask

    // Request one-cycle events from the peripheral model
    task automatic pulse(input logic [12:0] v);
        @(posedge pclk);
        fire <= v;
        @(posedge pclk);
        fire <= '0;
    endtask

    task automatic s_regs();
        rd(OFS_ENABLES_A, 32'h0);
        wr(OFS_ENABLES_A, 32'hffff_ffa5);
        rd(OFS_ENABLES_A, 32'ha5);
        wr(OFS_ENABLES_A, 32'h5a);
        rd(OFS_ENABLES_A, 32'h5a);
        wr(OFS_ENABLES_A, 32'h0);
    endtask

    // Each source alone, then both flag registers cleared
    task automatic s_flags();
        for (int i = 0; i < 13; i++) begin
            capcomp2_mode <= (i == 12) ? CC_COMPARE : CC_CAPTURE;
            pulse(13'h1 << i);
            rd(OFS_FLAGS_A, (i >= 4 && i < 12) ? 32'h1 << (i - 4) : 32'h0);
            rd(OFS_FLAGS_B, (i < 4) ? 32'h1 << i : ((i == 12) ? 32'h1 : 32'h0));
            wr(OFS_FLAGS_A, 32'h0);
            wr(OFS_FLAGS_B, 32'h0);
        end
    endtask

    task automatic s_unimpl();
        pulse(13'h100f);
        wr(OFS_FLAGS_B, 32'hffff_ffff);
        rd(OFS_FLAGS_B, 32'h0f);
        wr(OFS_FLAGS_B, 32'hf0);
        rd(OFS_FLAGS_B, 32'h0);
    endtask

    task automatic s_pwm();
        capcomp1_mode <= CC_PWM;
        capcomp2_mode <= CC_PWM;
        pulse(13'h1041);
        rd(OFS_FLAGS_A, 32'h0);
        rd(OFS_FLAGS_B, 32'h0);
        capcomp1_mode <= CC_COMPARE;
    endtask

    // Request appears one edge after flag, enable and the peripheral gate or priority bit meet
    task automatic s_irq();
        pulse(13'h010);
        rd(OFS_FLAGS_A, 32'h1);
        wr(OFS_ENABLES_A, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, peripheral_irq}, 32'h0);
        wr(OFS_GATES, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, peripheral_irq}, 32'h1);
        wr(OFS_ENABLES_A, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, peripheral_irq}, 32'h0);
        wr(OFS_FLAGS_A, 32'h0);
        // Second bank behind its own enable; priority bypasses the gate
        pulse(13'h008);
        wr(OFS_ENABLES_B, 32'h8);
        wr(OFS_GATES, 32'h4);
        rd(OFS_GATES, 32'h4);
        repeat (2) @(posedge pclk);
        chk({31'h0, peripheral_irq}, 32'h1);
        wr(OFS_FLAGS_B, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, peripheral_irq}, 32'h0);
    endtask

    // Event lands on the very edge of a clearing write
    task automatic s_race();
        fork
            wr(OFS_FLAGS_A, 32'h0);
            pulse(13'h010);
        join
        rd(OFS_FLAGS_A, 32'h1);
    endtask

    // Unmapped offset answers with an error and leaves the map alone
    task automatic s_unmapped();
        wr(12'h014, 32'hffff_ffff);
        chk({31'h0, last_err}, 32'h1);
        rd(12'h014, 32'h0);
        chk({31'h0, last_err}, 32'h1);
        rd(OFS_ENABLES_A, 32'h0);
        chk({31'h0, last_err}, 32'h0);
    endtask

    // Mid-run reset drops the request and clears enables and gates
    task automatic s_reset();
        pulse(13'h800);
        wr(OFS_ENABLES_A, 32'hff);
        repeat (2) @(posedge pclk);
        chk({24'h0, pending_a}, 32'h81);
        chk({31'h0, peripheral_irq}, 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk({31'h0, peripheral_irq}, 32'h0);
        rd(OFS_ENABLES_A, 32'h0);
        rd(OFS_GATES, 32'h0);
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_unmapped();
        s_flags();
        s_unimpl();
        s_pwm();
        s_irq();
        s_race();
        s_reset();
        give_verdict();
    end
endmodule
`default_nettype wire
